// ==== hw/mlm_pkg.sv ====
// Package for the mode latch and bus pin multiplexer: register map, fields,
// reset values and the AXI4-Lite carrier structs.
// Assumes a 200 MHz clock that stands in for the crystal.
package mlm_pkg;

  // Register byte offsets.
  localparam logic [7:0] MLM_OFF_STATUS = 8'h00;
  localparam logic [7:0] MLM_OFF_ASSIGN = 8'h04;
  localparam logic [7:0] MLM_OFF_EXT = 8'h08;
  localparam logic [7:0] MLM_OFF_ROUTE = 8'h0C;
  localparam logic [7:0] MLM_OFF_MODE = 8'h10;

  // Port E assignment register fields.
  localparam int MLM_CLK_DIS_BIT = 0;
  localparam int MLM_FREE_EN_BIT = 1;
  localparam int MLM_TRACK_EN_BIT = 2;
  // External bus control register fields.
  localparam int MLM_STR_EN_BIT = 0;
  localparam int MLM_STR_AMT_LSB = 1;
  // Pin routing register fields.
  localparam int MLM_PB_SEL_LSB = 0;
  localparam int MLM_PA_DISK_BIT = 2;
  localparam int MLM_PA6_STICK_BIT = 3;
  localparam int MLM_PE_CARD_BIT = 4;
  // Mode control register fields.
  localparam int MLM_VIS_BIT = 0;
  localparam int MLM_TAG_EN_BIT = 1;

  // Reset values.
  localparam logic [2:0] MLM_ASSIGN_RST = 3'h4;
  localparam logic [2:0] MLM_EXT_RST = 3'h7;
  localparam logic [4:0] MLM_ROUTE_RST = 5'h00;
  localparam logic [1:0] MLM_MODE_RST = 2'h0;

  // Port B selection codes in single chip mode.
  localparam logic [1:0] MLM_PB_TIMER = 2'h0;
  localparam logic [1:0] MLM_PB_CARD = 2'h1;
  localparam logic [1:0] MLM_PB_DISK = 2'h2;

  // Mode pins {b, a} both low select single chip; anything else is expanded.
  localparam logic [1:0] MLM_MODE_SINGLE = 2'h0;

  // Edges after reset release before the synchronised mode pins are latched.
  localparam logic [1:0] MLM_CAPT_CYCLES = 2'h2;

  localparam logic [1:0] MLM_RESP_OKAY = 2'h0;
  localparam logic [1:0] MLM_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } mlm_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mlm_axi_rsp_type;

endpackage

// ==== hw/mlm_pin_mux.sv ====
// Mode latch and bus pin multiplexer: latches the mode pins at reset release,
// shares ports A, B and E between the external bus and on-chip hosts, and
// makes the bus clock output with stretching and stop halt.
// Assumes pads resolve out/oe pairs, and that core-side inputs share clk.
//
// Operation
// - Mode pins are latched into three mode bits when reset is released.
// - Expanded, tagging on: debug pin low at bus clock fall tags high half.
// - Mode pin pull-downs are enabled only while reset is asserted.
// - Expanded: port A carries bus bits 15-8, port B bits 7-0.
// - Single chip: port B is timer channels or card/disk host data.
// - Single chip: port A bit 6 is stick bus state or host data.
// - Expanded, enabled: port E bit 7 flags a free bus cycle.
// - Port E mode pins serve as queue tracking outputs after reset.
// - Single chip: port E bits 7-5 may be card address lines 10-8.
// - After reset the bus clock runs at half the crystal rate.
// - Disable, visibility and stretch bits decide the bus clock on E4.
// - Stop mode halts the bus clock output; register bus and synchronisers keep running on clk.
// - Expanded: E4 starts as stretched bus clock; stretch amount is two bits.
`timescale 1ns/1ps

module mlm_pin_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus
  input wire mlm_pkg::mlm_axi_req_type axi_req,
  output mlm_pkg::mlm_axi_rsp_type axi_rsp,
  // Pins
  input wire logic debug_serial_pin,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  input wire logic [7:4] port_e_in,
  output logic [7:4] port_e_out,
  output logic [7:4] port_e_oe,
  output logic mode_pulldown_en,
  // Core side
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_write,
  input wire logic ext_access,
  input wire logic free_cycle_flag,
  input wire logic queue_track_1,
  input wire logic queue_track_0,
  input wire logic stop_mode,
  output logic tag_high_input,
  output logic [2:0] operating_mode,
  output logic [7:0] port_a_sync,
  output logic [7:0] port_b_sync,
  // Host controllers
  input wire logic [7:0] timer_channel_pins,
  input wire logic [7:0] timer_channel_oe,
  input wire logic [15:0] card_data_lines,
  input wire logic card_data_oe,
  input wire logic [15:0] disk_data_lines,
  input wire logic disk_data_oe,
  input wire logic stick_bus_state,
  input wire logic [10:8] card_address_lines
);
  import mlm_pkg::*;

  typedef struct packed {
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic [1:0] capt_cnt;
    logic captured;
    logic [2:0] mode_bits;
    logic pulldown_en;
    logic dbg_s1;
    logic dbg_s2;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pb_s1;
    logic [7:0] pb_s2;
    logic bus_clk;
    logic [1:0] str_cnt;
    logic tag_high;
    logic [7:0] pa_out;
    logic [7:0] pa_oe;
    logic [7:0] pb_out;
    logic [7:0] pb_oe;
    logic [7:4] pe_out;
    logic [7:4] pe_oe;
    logic [2:0] porte_assign_reg;
    logic [2:0] ext_bus_ctrl_reg;
    logic [4:0] route_reg;
    logic [1:0] mode_ctrl_reg;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mlm_state_type;

  mlm_state_type s;
  mlm_state_type next_s;
  logic expanded;
  logic stretch_on;
  logic clk_drive;
  logic card_sel;

  // Read mux; unmapped offsets answer zero and the caller flags SLVERR.
  function automatic logic [31:0] mlm_read(input mlm_state_type st, input logic [7:0] adr);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (adr)
      MLM_OFF_STATUS: v = {28'h000_0000, st.captured, st.mode_bits};
      MLM_OFF_ASSIGN: v = {29'h0000_0000, st.porte_assign_reg};
      MLM_OFF_EXT: v = {29'h0000_0000, st.ext_bus_ctrl_reg};
      MLM_OFF_ROUTE: v = {27'h000_0000, st.route_reg};
      MLM_OFF_MODE: v = {30'h0000_0000, st.mode_ctrl_reg};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mlm_mapped(input logic [7:0] adr);
    return adr == MLM_OFF_STATUS || adr == MLM_OFF_ASSIGN || adr == MLM_OFF_EXT ||
           adr == MLM_OFF_ROUTE || adr == MLM_OFF_MODE;
  endfunction

  assign expanded = s.mode_bits[1:0] != MLM_MODE_SINGLE;
  // Stretching only lengthens external accesses, since internal cycles never wait.
  assign stretch_on = expanded && s.ext_bus_ctrl_reg[MLM_STR_EN_BIT] && ext_access;
  // In single chip mode the clock is only worth driving when visibility is asked for.
  assign clk_drive = !s.porte_assign_reg[MLM_CLK_DIS_BIT] &&
                     (expanded || s.mode_ctrl_reg[MLM_VIS_BIT]);
  assign card_sel = s.route_reg[MLM_PE_CARD_BIT];

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s = s;

    // Pin synchronisers: the first stage feeds only the second.
    next_s.mode_s1 = {debug_serial_pin, port_e_in[6], port_e_in[5]};
    next_s.mode_s2 = s.mode_s1;
    next_s.dbg_s1 = debug_serial_pin;
    next_s.dbg_s2 = s.dbg_s1;
    next_s.pa_s1 = port_a_in;
    next_s.pa_s2 = s.pa_s1;
    next_s.pb_s1 = port_b_in;
    next_s.pb_s2 = s.pb_s1;

    // The pull-downs are released at the first edge after reset.
    next_s.pulldown_en = 1'b0;
    if (!s.captured) begin
      if (s.capt_cnt == MLM_CAPT_CYCLES) begin
        next_s.mode_bits = s.mode_s2;
        next_s.captured = 1'b1;
      end else begin
        next_s.capt_cnt = s.capt_cnt + 2'h1;
      end
    end
    // Once captured nothing writes mode_bits again until the next reset.

    // Bus clock: toggles every crystal cycle, high phase stretched on demand.
    next_s.tag_high = 1'b0;
    if (!stop_mode) begin
      if (s.str_cnt != 2'h0) begin
        next_s.str_cnt = s.str_cnt - 2'h1;
      end else begin
        next_s.bus_clk = ~s.bus_clk;
        if (!s.bus_clk && stretch_on) begin
          next_s.str_cnt = s.ext_bus_ctrl_reg[MLM_STR_AMT_LSB +: 2];
        end
        // Falling edge: sample the tag request on the debug pin.
        if (s.bus_clk) begin
          next_s.tag_high = expanded && s.mode_ctrl_reg[MLM_TAG_EN_BIT] && !s.dbg_s2;
        end
      end
    end

    // Ports A and B.
    if (expanded) begin
      // Address while the bus clock is low, data while high.
      next_s.pa_out = next_s.bus_clk ? bus_wdata[15:8] : bus_addr[15:8];
      next_s.pb_out = next_s.bus_clk ? bus_wdata[7:0] : bus_addr[7:0];
      next_s.pa_oe = {8{!next_s.bus_clk || bus_write}};
      next_s.pb_oe = {8{!next_s.bus_clk || bus_write}};
    end else begin
      unique case (s.route_reg[MLM_PB_SEL_LSB +: 2])
        MLM_PB_TIMER: begin
          next_s.pb_out = timer_channel_pins;
          next_s.pb_oe = timer_channel_oe;
        end
        MLM_PB_CARD: begin
          next_s.pb_out = card_data_lines[7:0];
          next_s.pb_oe = {8{card_data_oe}};
        end
        MLM_PB_DISK: begin
          next_s.pb_out = disk_data_lines[7:0];
          next_s.pb_oe = {8{disk_data_oe}};
        end
        default: begin
          next_s.pb_out = 8'h00;
          next_s.pb_oe = 8'h00;
        end
      endcase
      if (s.route_reg[MLM_PA_DISK_BIT]) begin
        next_s.pa_out = disk_data_lines[15:8];
        next_s.pa_oe = {8{disk_data_oe}};
      end else begin
        next_s.pa_out = card_data_lines[15:8];
        next_s.pa_oe = {8{card_data_oe}};
      end
      if (s.route_reg[MLM_PA6_STICK_BIT]) begin
        next_s.pa_out[6] = stick_bus_state;
        next_s.pa_oe[6] = 1'b1;
      end
    end

    // Port E bits 7 to 4.
    next_s.pe_out = 4'h0;
    next_s.pe_oe = 4'h0;
    if (!expanded && card_sel) begin
      next_s.pe_out[7:5] = card_address_lines;
      next_s.pe_oe[7:5] = 3'h7;
    end else begin
      if (expanded && s.porte_assign_reg[MLM_FREE_EN_BIT]) begin
        next_s.pe_out[7] = free_cycle_flag;
        next_s.pe_oe[7] = 1'b1;
      end
      if (s.captured && s.porte_assign_reg[MLM_TRACK_EN_BIT]) begin
        next_s.pe_out[6:5] = {queue_track_1, queue_track_0};
        next_s.pe_oe[6:5] = 2'h3;
      end
    end
    next_s.pe_out[4] = next_s.bus_clk;
    next_s.pe_oe[4] = clk_drive;

    // AXI4-Lite write path: address and data taken in either order.
    if (s.awready && axi_req.awvalid) begin
      next_s.aw_have = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (s.wready && axi_req.wvalid) begin
      next_s.w_have = 1'b1;
      next_s.wdata = axi_req.wdata[7:0];
      next_s.wstrb0 = axi_req.wstrb[0];
    end
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_have && s.w_have && !s.bvalid) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mlm_mapped(s.awaddr) ? MLM_RESP_OKAY : MLM_RESP_SLVERR;
      if (s.wstrb0) begin
        unique case (s.awaddr)
          MLM_OFF_ASSIGN: next_s.porte_assign_reg = s.wdata[2:0];
          MLM_OFF_EXT: next_s.ext_bus_ctrl_reg = s.wdata[2:0];
          MLM_OFF_ROUTE: next_s.route_reg = s.wdata[4:0];
          MLM_OFF_MODE: next_s.mode_ctrl_reg = s.wdata[1:0];
          default: next_s.bresp = next_s.bresp;
        endcase
      end
    end
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;

    // AXI4-Lite read path: one read in flight.
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && axi_req.arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = mlm_read(s, axi_req.araddr);
      next_s.rresp = mlm_mapped(axi_req.araddr) ? MLM_RESP_OKAY : MLM_RESP_SLVERR;
    end
    next_s.arready = !next_s.rvalid;
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.pulldown_en <= 1'b1;
      s.porte_assign_reg <= MLM_ASSIGN_RST;
      s.ext_bus_ctrl_reg <= MLM_EXT_RST;
      s.route_reg <= MLM_ROUTE_RST;
      s.mode_ctrl_reg <= MLM_MODE_RST;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign axi_rsp.awready = s.awready;
  assign axi_rsp.wready = s.wready;
  assign axi_rsp.bvalid = s.bvalid;
  assign axi_rsp.bresp = s.bresp;
  assign axi_rsp.arready = s.arready;
  assign axi_rsp.rvalid = s.rvalid;
  assign axi_rsp.rdata = s.rdata;
  assign axi_rsp.rresp = s.rresp;
  assign port_a_out = s.pa_out;
  assign port_a_oe = s.pa_oe;
  assign port_b_out = s.pb_out;
  assign port_b_oe = s.pb_oe;
  assign port_e_out = s.pe_out;
  assign port_e_oe = s.pe_oe;
  assign mode_pulldown_en = s.pulldown_en;
  assign tag_high_input = s.tag_high;
  assign operating_mode = s.mode_bits;
  assign port_a_sync = s.pa_s2;
  assign port_b_sync = s.pb_s2;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  mode_capture_a: assert property ($rose(s.captured) |->
    s.mode_bits == $past(s.mode_s2))
    else $error("mode bits differ from latched pins");
  mode_hold_a: assert property (s.captured |=> $stable(s.mode_bits) && s.captured)
    else $error("mode bits changed after capture");
  pulldown_off_a: assert property (s.captured |-> !mode_pulldown_en)
    else $error("pull-down active outside reset");
  clk_half_a: assert property (!stop_mode && s.str_cnt == 2'h0 |=>
    s.bus_clk != $past(s.bus_clk))
    else $error("bus clock failed to toggle");
  stop_halt_a: assert property (stop_mode |=> $stable(s.bus_clk) && $stable(s.str_cnt))
    else $error("bus clock moved in stop mode");
  stretch_hold_a: assert property (s.str_cnt != 2'h0 && !stop_mode |=>
    $stable(s.bus_clk))
    else $error("bus clock moved while stretched");
  addr_phase_a: assert property (expanded && !next_s.bus_clk |=>
    port_a_out == $past(bus_addr[15:8]) && port_b_out == $past(bus_addr[7:0]) &&
    port_a_oe == 8'hFF && port_b_oe == 8'hFF)
    else $error("address not on ports in low phase");
  tag_edge_a: assert property (tag_high_input |->
    $past(s.bus_clk) && !s.bus_clk && expanded)
    else $error("tag pulse outside a falling bus clock edge");
  free_cycle_a: assert property (expanded && s.porte_assign_reg[MLM_FREE_EN_BIT] &&
    !card_sel |=> port_e_oe[7] && port_e_out[7] == $past(free_cycle_flag))
    else $error("free cycle flag not driven on port E bit 7");

endmodule // mlm_pin_mux

// ==== verification/mlm_ext_mem.sv ====
// External memory model on the multiplexed expanded bus.
// Assumes the bench resolves each port pin from the device's enables.
`timescale 1ns/1ps

module mlm_ext_mem (
  // Clock
  input wire logic clk,
  // Bus pins
  input wire logic [7:0] pa,
  input wire logic [7:0] pb,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_oe,
  input wire logic bus_clk_in,
  // Model side
  output logic [15:0] drive,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data
);
  logic [15:0] mem [16];

  initial begin
    drive = 16'h0000;
    wr_addr = 16'h0000;
    wr_data = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  ////////////////////////////////////////
  // Address is taken in the low phase, data in the high phase.
  // Released lines show the inverse of the last value, so a stale copy never passes.
  always @(posedge clk) begin
    if (!bus_clk_in && (&pa_oe) && (&pb_oe))
      wr_addr <= {pa, pb};
    if (bus_clk_in && (&pa_oe)) begin
      wr_data <= {pa, pb};
      mem[wr_addr[3:0]] <= {pa, pb};
    end
    drive <= (bus_clk_in && !(|pa_oe)) ? mem[wr_addr[3:0]] : ~drive;
  end
endmodule // mlm_ext_mem

// ==== verification/mlm_tb.sv ====
// Self-checking bench for the mode latch and bus pin multiplexer.
// Assumes the design package and the external memory model compile first.
`timescale 1ns/1ps

module tb;
  import mlm_pkg::*;

  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } mlm_row_type;

  localparam mlm_row_type ROWS [8] = '{
    '{1'h0, MLM_OFF_ASSIGN, 32'h0, 32'h0000_0004, MLM_RESP_OKAY},
    '{1'h0, MLM_OFF_EXT, 32'h0, 32'h0000_0007, MLM_RESP_OKAY},
    '{1'h0, MLM_OFF_ROUTE, 32'h0, 32'h0, MLM_RESP_OKAY},
    '{1'h0, MLM_OFF_MODE, 32'h0, 32'h0, MLM_RESP_OKAY},
    '{1'h0, 8'h14, 32'h0, 32'h0, MLM_RESP_SLVERR},
    '{1'h1, 8'h14, 32'h0000_00FF, 32'h0, MLM_RESP_SLVERR},
    '{1'h1, MLM_OFF_EXT, 32'hFFFF_FF03, 32'h0000_0003, MLM_RESP_OKAY},
    '{1'h1, MLM_OFF_ROUTE, 32'h0000_001F, 32'h0000_001F, MLM_RESP_OKAY}
  };

  logic clk, sys_rst, dbg, bus_write, ext_access, free_f, q1, q0, stop_mode, b;
  logic card_oe, disk_oe, stick, pd_en, tag;
  mlm_axi_req_type req;
  mlm_axi_rsp_type rsp;
  logic [15:0] bus_addr, bus_wdata, card, disk, ext_drv, wa, wd;
  logic [7:0] tmr, tmr_oe, pa_out, pa_oe, pb_out, pb_oe, pa_in, pb_in, pa_sync, pb_sync;
  logic [7:4] strap_e, pe_out, pe_oe, pe_in;
  logic [10:8] cadr;
  logic [2:0] opmode;
  logic [31:0] rd;
  logic [1:0] rr;
  int err_total, total_checks, n;

  // Each pin shows the device's level where it drives, else the far side's.
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_drv[15:8]);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_drv[7:0]);
  assign pe_in = (pe_oe & pe_out) | (~pe_oe & strap_e);

  mlm_pin_mux dut_u (.clk(clk), .sys_rst(sys_rst), .axi_req(req), .axi_rsp(rsp),
    .debug_serial_pin(dbg), .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe),
    .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe(pb_oe), .port_e_in(pe_in),
    .port_e_out(pe_out), .port_e_oe(pe_oe), .mode_pulldown_en(pd_en),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .ext_access(ext_access), .free_cycle_flag(free_f), .queue_track_1(q1),
    .queue_track_0(q0), .stop_mode(stop_mode), .tag_high_input(tag),
    .operating_mode(opmode), .port_a_sync(pa_sync), .port_b_sync(pb_sync),
    .timer_channel_pins(tmr), .timer_channel_oe(tmr_oe), .card_data_lines(card),
    .card_data_oe(card_oe), .disk_data_lines(disk), .disk_data_oe(disk_oe),
    .stick_bus_state(stick), .card_address_lines(cadr));

  mlm_ext_mem mem_u (.clk(clk), .pa(pa_in), .pb(pb_in), .pa_oe(pa_oe), .pb_oe(pb_oe),
    .bus_clk_in(pe_out[4]), .drive(ext_drv), .wr_addr(wa), .wr_data(wd));

  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic tmo(input string m);
    fail(m);
    end_of_test();
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) fail(m);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'h1;
    req.wvalid <= 1'h1;
    req.bready <= 1'h1;
    r = 2'h3;
    for (k = 0; k < 64; k++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid) begin
        r = rsp.bresp;
        req.bready <= 1'h0;
        break;
      end
    end
    if (k == 64) tmo("write timeout");
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    d = 32'h0;
    r = 2'h3;
    for (k = 0; k < 64; k++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'h0;
        break;
      end
    end
    if (k == 64) tmo("read timeout");
  endtask

  // Straps the mode pins, pulses reset, then moves the pins to show they are ignored.
  task automatic do_reset(input logic [2:0] m);
    @(posedge clk);
    dbg <= m[2];
    strap_e[6:5] <= m[1:0];
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    chk(32'(pd_en), 32'h1, "pulldown off in reset");
    sys_rst <= 1'h0;
    repeat (5) @(posedge clk);
    chk(32'(pd_en), 32'h0, "pulldown on after reset");
    chk(32'(opmode), 32'(m), "mode not latched");
    dbg <= ~m[2];
    strap_e[6:5] <= ~m[1:0];
    repeat (4) @(posedge clk);
    chk(32'(opmode), 32'(m), "mode changed");
    axr(MLM_OFF_STATUS, rd, rr);
    chk(rd, 32'(m) | 32'h0000_0008, "status");
    dbg <= 1'h1;
  endtask

  task automatic hi_len(output int len);
    int k;
    len = 0;
    for (k = 0; k < 64 && pe_out[4] !== 1'h0; k++) @(posedge clk);
    if (k == 64) tmo("bus clock stuck");
    for (k = 0; k < 64 && pe_out[4] !== 1'h1; k++) @(posedge clk);
    if (k == 64) tmo("bus clock stuck");
    for (k = 0; k < 64 && pe_out[4] === 1'h1; k++) begin
      len++;
      @(posedge clk);
    end
    if (k == 64) tmo("bus clock stuck");
  endtask

  task automatic tag_cnt(output int c);
    repeat (6) @(posedge clk);
    c = 0;
    repeat (16) begin
      @(posedge clk);
      if (tag === 1'h1) c++;
    end
  endtask

  ////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    sys_rst = 1'h1;
    req = '0;
    dbg = 1'h1;
    strap_e = 4'h0;
    bus_addr = 16'h0;
    bus_wdata = 16'h0;
    bus_write = 1'h0;
    ext_access = 1'h0;
    free_f = 1'h0;
    q1 = 1'h0;
    q0 = 1'h0;
    stop_mode = 1'h0;
    tmr = 8'h96;
    tmr_oe = 8'hF0;
    card = 16'h5AC3;
    card_oe = 1'h1;
    disk = 16'h69E1;
    disk_oe = 1'h1;
    stick = 1'h1;
    cadr = 3'h5;
    err_total = 0;
    total_checks = 0;
    do_reset(3'h5);
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) begin
        axw(ROWS[i].a, ROWS[i].d, rr);
        chk(32'(rr), 32'(ROWS[i].r), "write response");
      end
      axr(ROWS[i].a, rd, rr);
      chk(rd, ROWS[i].e, "read data");
      chk(32'(rr), 32'(ROWS[i].r), "read response");
    end
    do_reset(3'h5);
    hi_len(n);
    chk(32'(n), 32'h1, "bus clock not half rate");
    chk(32'(pe_oe[4]), 32'h1, "bus clock pin off");
    ext_access <= 1'h1;
    hi_len(n);
    hi_len(n);
    chk(32'(n), 32'h4, "stretch length");
    ext_access <= 1'h0;
    stop_mode <= 1'h1;
    repeat (3) @(posedge clk);
    b = pe_out[4];
    n = 0;
    repeat (8) begin
      @(posedge clk);
      if (pe_out[4] !== b) n++;
    end
    chk(32'(n), 32'h0, "bus clock runs in stop");
    stop_mode <= 1'h0;
    bus_addr <= 16'hA55A;
    bus_wdata <= 16'h3CC3;
    bus_write <= 1'h1;
    repeat (3) @(posedge clk);
    repeat (6) begin
      @(posedge clk);
      chk(32'({pa_out, pb_out}), pe_out[4] ? 32'h3CC3 : 32'hA55A, "bus halves");
    end
    chk(32'({pa_oe, pb_oe}), 32'h0000_FFFF, "bus drive");
    chk(32'({wa, wd}), 32'hA55A_3CC3, "memory capture");
    bus_write <= 1'h0;
    ext_access <= 1'h1;
    hi_len(n);
    hi_len(n);
    chk(32'(n), 32'h4, "read stretch");
    chk(32'({pa_sync, pb_sync}), 32'h0000_3CC3, "read data from memory");
    ext_access <= 1'h0;
    axw(MLM_OFF_MODE, 32'h0000_0002, rr);
    dbg <= 1'h0;
    tag_cnt(n);
    chk(32'(n), 32'h8, "tag pulses");
    dbg <= 1'h1;
    tag_cnt(n);
    chk(32'(n), 32'h0, "tag without request");
    axw(MLM_OFF_MODE, 32'h0, rr);
    dbg <= 1'h0;
    tag_cnt(n);
    chk(32'(n), 32'h0, "tag while disabled");
    dbg <= 1'h1;
    axw(MLM_OFF_ASSIGN, 32'h0000_0006, rr);
    free_f <= 1'h1;
    q1 <= 1'h1;
    repeat (3) @(posedge clk);
    chk(32'({pe_out[7:5], pe_oe[7]}), 32'hD, "free and queue");
    free_f <= 1'h0;
    q1 <= 1'h0;
    q0 <= 1'h1;
    repeat (3) @(posedge clk);
    chk(32'(pe_out[7:5]), 32'h1, "free and queue low");
    axw(MLM_OFF_ASSIGN, 32'h0000_0007, rr);
    repeat (3) @(posedge clk);
    chk(32'(pe_oe[4]), 32'h0, "bus clock disable");
    do_reset(3'h0);
    chk(32'(pe_oe[4]), 32'h0, "single chip clock pin");
    axw(MLM_OFF_MODE, 32'h0000_0001, rr);
    repeat (3) @(posedge clk);
    chk(32'(pe_oe[4]), 32'h1, "visibility");
    for (n = 0; n < 3; n++) begin
      axw(MLM_OFF_ROUTE, 32'(n) | 32'h0000_0008, rr);
      repeat (3) @(posedge clk);
      chk(32'(pb_out), n == 0 ? 32'h96 : n == 1 ? 32'hC3 : 32'hE1, "port b");
      chk(32'(pb_oe), n == 0 ? 32'hF0 : 32'hFF, "port b drive");
      chk(32'(pa_out[6]), 32'h1, "stick state");
    end
    axw(MLM_OFF_ROUTE, 32'h0000_0011, rr);
    repeat (3) @(posedge clk);
    chk(32'({pa_out, pe_out[7:5]}), 32'h0000_02D5, "card lines");
    disk_oe <= 1'h0;
    axw(MLM_OFF_ROUTE, 32'h0000_0007, rr);
    repeat (3) @(posedge clk);
    chk({pa_out, pa_oe, pb_out, pb_oe}, 32'h6900_0000, "disk byte");
    end_of_test();
  end
endmodule // tb
